// >>> psc_pkg.sv
/*
 * Constants for the strap-driven mode configuration block: register offsets,
 * field positions, reset values, operating-mode codes and timing counts.
 * Assumes a single 10 MHz system clock; no other file defines these names.
 */
package psc_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_PERIOD_NS   = 100;
	localparam int STRAP_SETTLE_NS = 400;                       // Pins released before capture
	localparam int SYNC_DEPTH      = 2;
	// Least time rounds up, never below one cycle, plus the synchroniser depth
	localparam int STRAP_SETTLE_CYC = ((STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int STRAP_WAIT_CYC  = STRAP_SETTLE_CYC + SYNC_DEPTH;
	localparam int WAIT_CNT_W      = 4;

	// ==========================================================
	// Register bus defaults
	localparam int ADDR_W_DEF = 4;
	localparam int DATA_W_DEF = 16;

	// ==========================================================
	// Register offsets (word index on the plain port)
	localparam logic [3:0] REG_CONTROL = 4'h0;
	localparam logic [3:0] REG_STRAP   = 4'h1;
	localparam logic [3:0] REG_MODE    = 4'h2;
	localparam logic [3:0] REG_STATUS  = 4'h3;

	// Control register fields
	localparam int CTRL_SOFT_RESET_BIT = 0;

	// Strap register fields
	localparam int STRAP_OPMODE_LSB  = 0;                      // Three bits
	localparam int STRAP_STATUS_BIT  = 3;
	localparam int STRAP_RMII_BIT    = 4;
	localparam int STRAP_NIBBLE_BIT  = 5;

	// Status register fields
	localparam int STAT_POWER_DOWN_BIT = 0;
	localparam int STAT_RUNNING_BIT    = 1;
	localparam int STAT_SIG_VALID_BIT  = 2;
	localparam int STAT_AUTO_XOVER_BIT = 3;
	localparam int STAT_SERIAL_BIT     = 4;

	// ==========================================================
	// Decoded mode vector fields
	localparam int MODE_W          = 8;
	localparam int MODE_AUTONEG    = 0;
	localparam int MODE_ADV_10HD   = 1;
	localparam int MODE_ADV_10FD   = 2;
	localparam int MODE_ADV_100HD  = 3;
	localparam int MODE_ADV_100FD  = 4;
	localparam int MODE_FORCE_100  = 5;
	localparam int MODE_FORCE_FD   = 6;
	localparam int MODE_FIBER      = 7;

	// Operating-mode strap codes
	localparam logic [2:0] OPM_DUAL_HD    = 3'h0;
	localparam logic [2:0] OPM_FX100_HD   = 3'h1;
	localparam logic [2:0] OPM_FX100_FD   = 3'h2;
	localparam logic [2:0] OPM_TP10_HD    = 3'h3;
	localparam logic [2:0] OPM_TP10_FD    = 3'h4;
	localparam logic [2:0] OPM_TP100_HD   = 3'h5;
	localparam logic [2:0] OPM_TP100_FD   = 3'h6;
	localparam logic [2:0] OPM_AUTO_ALL   = 3'h7;

	// Values after reset
	localparam logic [5:0]        RST_STRAPS = 6'h00;
	localparam logic [MODE_W-1:0] RST_MODE   = 8'h00;

	typedef enum {PSC_PH_SETTLE, PSC_PH_RUN} psc_phase_type;

endpackage

// >>> psc_strap_config.sv
/*
 * Strap capture and pin-role selection for a 10/100 transceiver: samples the
 * mode straps after hardware reset, decodes speed, duplex and media, selects
 * the MAC-side pin map, handles power-down and the cable or link status pin.
 * Assumes one 10 MHz clock; pins arrive asynchronously, core signals on clock.
 */
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/10ps

module psc_strap_config #(
	parameter int ADDR_W = psc_pkg::ADDR_W_DEF,
	parameter int DATA_W = psc_pkg::DATA_W_DEF
) (
	// Clock and reset
	input  wire logic              I_CLOCK,
	input  wire logic              I_RESETN,
	// Register port
	input  wire logic [ADDR_W-1:0] I_REG_ADDR,
	input  wire logic [DATA_W-1:0] I_REG_WDATA,
	input  wire logic              I_REG_WRITE,
	input  wire logic              I_REG_READ,
	output logic      [DATA_W-1:0] O_REG_RDATA,
	// Strap-sharing LED pins
	input  wire logic              I_INDICATOR_A_IN,
	output logic                   O_INDICATOR_A_OUT,
	output logic                   O_INDICATOR_A_OE_N,
	input  wire logic              I_INDICATOR_B_IN,
	output logic                   O_INDICATOR_B_OUT,
	output logic                   O_INDICATOR_B_OE_N,
	input  wire logic              I_INDICATOR_C_IN,
	output logic                   O_INDICATOR_C_OUT,
	output logic                   O_INDICATOR_C_OE_N,
	// Cable or link status pin
	input  wire logic              I_STATUS_PIN_IN,
	output logic                   O_STATUS_PIN_OUT,
	output logic                   O_STATUS_PIN_OE_N,
	// Collision pin (interface strap)
	input  wire logic              I_COL_PIN_IN,
	output logic                   O_COL_PIN_OUT,
	output logic                   O_COL_PIN_OE_N,
	// Receive clock pin (10 Mbps interface strap)
	input  wire logic              I_RXCLK_PIN_IN,
	output logic                   O_RXCLK_PIN_OUT,
	output logic                   O_RXCLK_PIN_OE_N,
	// Control pins
	input  wire logic              I_POWER_DOWN_IN,
	input  wire logic              I_CROSSOVER_DISABLE_IN,
	input  wire logic              I_FIBER_SIGNAL_DETECT,
	// MAC transmit pins
	input  wire logic [3:0]        I_MAC_TXD,
	input  wire logic              I_MAC_TXEN,
	input  wire logic              I_MAC_TXER,
	// MAC receive outputs
	output logic      [3:0]        O_MAC_RXD,
	output logic                   O_MAC_RXDV,
	output logic                   O_MAC_RXER,
	output logic                   O_MAC_CRS,
	// Core side, same clock
	input  wire logic [3:0]        I_CORE_RXD,
	input  wire logic              I_CORE_RXDV,
	input  wire logic              I_CORE_RXER,
	input  wire logic              I_CORE_CRS,
	input  wire logic              I_CORE_COL,
	input  wire logic              I_CORE_RXCLK_LEVEL,
	input  wire logic              I_CORE_TP_SIGNAL,
	input  wire logic              I_CORE_CABLE_PRESENT,
	input  wire logic              I_CORE_LINK_UP,
	input  wire logic              I_CORE_LED_A,
	input  wire logic              I_CORE_LED_B,
	input  wire logic              I_CORE_LED_C,
	output logic      [3:0]        O_CORE_TXD,
	output logic                   O_CORE_TXEN,
	output logic                   O_CORE_TXER,
	// Configuration outputs to the core
	output logic [psc_pkg::MODE_W-1:0] O_MODE,
	output logic                   O_BLOCKS_POWER_ON,
	output logic                   O_CORE_SOFT_RESET,
	output logic                   O_AUTO_CROSSOVER_EN,
	output logic                   O_RX_SIGNAL_VALID,
	output logic                   O_REFCLK_50M_SEL,
	output logic                   O_RMII_MODE,
	output logic                   O_SERIAL_SEVEN_WIRE_MODE
);
	import psc_pkg::*;

	// ==========================================================
	// Elaboration checks
	if (ADDR_W < 2 || DATA_W < 8 || STRAP_WAIT_CYC >= (1 << WAIT_CNT_W)) begin : g_bad_cfg
		$error("psc_strap_config: ADDR_W below 2, DATA_W below 8 or strap wait too long for its counter");
	end

	// Decode an operating-mode strap code into the mode vector
	function automatic logic [MODE_W-1:0] decode_opmode(input logic [2:0] code);
		logic [MODE_W-1:0] m;
		// Both negotiating codes advertise the half-duplex pair; forced codes advertise nothing
		m                 = '0;
		m[MODE_AUTONEG]   = (code == OPM_AUTO_ALL) || (code == OPM_DUAL_HD);
		m[MODE_ADV_10HD]  = m[MODE_AUTONEG];
		m[MODE_ADV_100HD] = m[MODE_AUTONEG];
		m[MODE_ADV_10FD]  = (code == OPM_AUTO_ALL);
		m[MODE_ADV_100FD] = (code == OPM_AUTO_ALL);
		m[MODE_FIBER]     = (code == OPM_FX100_HD) || (code == OPM_FX100_FD);
		m[MODE_FORCE_100] = m[MODE_FIBER] || (code == OPM_TP100_HD) || (code == OPM_TP100_FD);
		m[MODE_FORCE_FD]  = (code == OPM_FX100_FD) || (code == OPM_TP10_FD) || (code == OPM_TP100_FD);
		return m;
	endfunction

	// ==========================================================
	// Pin synchronisers: every pin input passes two flip-flops
	localparam int NSYNC = 15;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] meta_q;
	logic [NSYNC-1:0] sync_q;

	assign pin_raw = {I_MAC_TXER, I_MAC_TXEN, I_MAC_TXD, I_FIBER_SIGNAL_DETECT, I_CROSSOVER_DISABLE_IN,
		I_POWER_DOWN_IN, I_RXCLK_PIN_IN, I_COL_PIN_IN, I_STATUS_PIN_IN, I_INDICATOR_C_IN,
		I_INDICATOR_B_IN, I_INDICATOR_A_IN};

	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pin_raw;
			sync_q <= meta_q;
		end
	end

	// Named taps on the synchronised pins
	wire logic       pd_pin    = sync_q[6];
	wire logic       xover_dis = sync_q[7];
	wire logic       sig_det   = sync_q[8];
	wire logic [3:0] tx_d      = sync_q[12:9];
	wire logic       tx_en     = sync_q[13];
	wire logic       tx_er     = sync_q[14];

	// ==========================================================
	// Strap capture after hardware reset release
	psc_phase_type          phase_q;
	logic [WAIT_CNT_W-1:0]  wait_q;
	logic [5:0]             straps_q;   // {nibble, rmii, status, op[2:0]}
	logic [MODE_W-1:0]      mode_q;
	logic                   running;

	assign running = (phase_q == PSC_PH_RUN);

	// Pins stay released until the straps are caught; capture happens once per hardware reset
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			phase_q  <= PSC_PH_SETTLE;
			wait_q   <= '0;
			straps_q <= RST_STRAPS;
			mode_q   <= RST_MODE;
		end else if (phase_q == PSC_PH_SETTLE) begin
			if (wait_q == WAIT_CNT_W'(STRAP_WAIT_CYC - 1)) begin
				phase_q  <= PSC_PH_RUN;
				straps_q <= sync_q[5:0];
				mode_q   <= decode_opmode(sync_q[2:0]);
			end else begin
				wait_q <= wait_q + WAIT_CNT_W'(1);
			end
		end
	end
	// Straps are written nowhere else, so they hold until the next hardware reset

	logic rmii_sel;
	logic serial_sel;
	logic fiber_sel;
	assign rmii_sel   = straps_q[4];
	assign serial_sel = !straps_q[5] && !rmii_sel;   // Reduced MII takes priority over serial
	assign fiber_sel  = mode_q[MODE_FIBER];

	// ==========================================================
	// Register write side: soft reset is a self-clearing pulse
	wire logic wr_ctrl  = I_REG_WRITE && (I_REG_ADDR == ADDR_W'(REG_CONTROL));
	wire logic soft_rst = wr_ctrl && I_REG_WDATA[CTRL_SOFT_RESET_BIT];

	// ==========================================================
	// Power-down: entry on the pin, exit only through a reset with the pin low.
	// The soft-reset pulse lives here too, as it is the software way out.
	logic pd_q;
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			pd_q              <= 1'b0;
			O_CORE_SOFT_RESET <= 1'b0;
		end else begin
			O_CORE_SOFT_RESET <= soft_rst;
			if (running && pd_pin) begin
				pd_q <= 1'b1;
			end else if (soft_rst && !pd_pin) begin
				pd_q <= 1'b0;
			end
		end
	end

	wire logic active = running && !pd_q;

	// ==========================================================
	// Configuration outputs
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_MODE                   <= RST_MODE;
			O_BLOCKS_POWER_ON        <= 1'b0;
			O_AUTO_CROSSOVER_EN      <= 1'b0;
			O_RX_SIGNAL_VALID        <= 1'b0;
			O_REFCLK_50M_SEL         <= 1'b0;
			O_RMII_MODE              <= 1'b0;
			O_SERIAL_SEVEN_WIRE_MODE <= 1'b0;
		end else begin
			O_MODE                   <= mode_q;
			O_BLOCKS_POWER_ON        <= active;
			O_AUTO_CROSSOVER_EN      <= running && !xover_dis;
			// Fiber ignores the twisted-pair detector; no detect means no signal
			O_RX_SIGNAL_VALID        <= active && (fiber_sel ? sig_det : I_CORE_TP_SIGNAL);
			O_REFCLK_50M_SEL         <= running && rmii_sel;
			O_RMII_MODE              <= running && rmii_sel;
			O_SERIAL_SEVEN_WIRE_MODE <= running && serial_sel;
		end
	end

	// ==========================================================
	// MAC-side data path: pin map per interface, quiet in power-down.
	// Data bits carried: two in reduced MII, one in serial, four in normal MII, none when inactive
	wire logic [3:0] data_mask  = !active ? 4'h0 : rmii_sel ? 4'h3 : serial_sel ? 4'h1 : 4'hF;
	wire logic       nibble_map = active && !rmii_sel && !serial_sel;

	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_MAC_RXD   <= 4'h0;
			O_MAC_RXDV  <= 1'b0;
			O_MAC_RXER  <= 1'b0;
			O_MAC_CRS   <= 1'b0;
			O_CORE_TXD  <= 4'h0;
			O_CORE_TXEN <= 1'b0;
			O_CORE_TXER <= 1'b0;
		end else begin
			O_MAC_RXD   <= I_CORE_RXD & data_mask;
			O_MAC_RXDV  <= rmii_sel ? active && I_CORE_CRS : nibble_map && I_CORE_RXDV;
			O_MAC_RXER  <= nibble_map && I_CORE_RXER;
			O_MAC_CRS   <= active && !rmii_sel && I_CORE_CRS;
			O_CORE_TXD  <= tx_d & data_mask;
			O_CORE_TXEN <= active && tx_en;
			O_CORE_TXER <= nibble_map && tx_er;
		end
	end

	// ==========================================================
	// Collision and receive clock pins: released until running, unused in reduced MII
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_COL_PIN_OUT    <= 1'b0;
			O_COL_PIN_OE_N   <= 1'b1;
			O_RXCLK_PIN_OUT  <= 1'b0;
			O_RXCLK_PIN_OE_N <= 1'b1;
		end else begin
			O_COL_PIN_OUT    <= active && I_CORE_COL;
			O_COL_PIN_OE_N   <= !(running && !rmii_sel);
			O_RXCLK_PIN_OUT  <= active && I_CORE_RXCLK_LEVEL;
			O_RXCLK_PIN_OE_N <= !(running && !rmii_sel);
		end
	end

	// ==========================================================
	// LED and status pins: driven only after capture, polarity set by the strap level
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_INDICATOR_A_OUT  <= 1'b0;
			O_INDICATOR_B_OUT  <= 1'b0;
			O_INDICATOR_C_OUT  <= 1'b0;
			O_INDICATOR_A_OE_N <= 1'b1;
			O_INDICATOR_B_OE_N <= 1'b1;
			O_INDICATOR_C_OE_N <= 1'b1;
			O_STATUS_PIN_OUT   <= 1'b0;
			O_STATUS_PIN_OE_N  <= 1'b1;
		end else begin
			// A pulled-up strap means the LED sinks current, so it lights low
			O_INDICATOR_A_OUT  <= I_CORE_LED_A ^ straps_q[0];
			O_INDICATOR_B_OUT  <= I_CORE_LED_B ^ straps_q[1];
			O_INDICATOR_C_OUT  <= I_CORE_LED_C ^ straps_q[2];
			O_INDICATOR_A_OE_N <= !running;
			O_INDICATOR_B_OE_N <= !running;
			O_INDICATOR_C_OE_N <= !running;
			O_STATUS_PIN_OUT   <= straps_q[3] ? !I_CORE_LINK_UP
				: I_CORE_CABLE_PRESENT;
			O_STATUS_PIN_OE_N  <= !running;
		end
	end

	// ==========================================================
	// Register read side: answers in any power state, data for one cycle only
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (I_REG_ADDR == ADDR_W'(REG_STRAP)) begin
			rd_mux[5:0] = straps_q;
		end else if (I_REG_ADDR == ADDR_W'(REG_MODE)) begin
			rd_mux[MODE_W-1:0] = mode_q;
		end else if (I_REG_ADDR == ADDR_W'(REG_STATUS)) begin
			rd_mux[STAT_POWER_DOWN_BIT] = pd_q;
			rd_mux[STAT_RUNNING_BIT]    = running;
			rd_mux[STAT_SIG_VALID_BIT]  = O_RX_SIGNAL_VALID;
			rd_mux[STAT_AUTO_XOVER_BIT] = O_AUTO_CROSSOVER_EN;
			rd_mux[STAT_SERIAL_BIT]     = running && serial_sel;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_REG_RDATA <= '0;
		end else begin
			O_REG_RDATA <= I_REG_READ ? rd_mux : '0;
		end
	end

endmodule

// >>> psc_assertions.sv
/* Concurrent checks on the strap configuration block, seen from its top-level ports.
   Assumes a bind from the testbench and two-flop synchronisers on the pins. */
`timescale 1ns/10ps
module psc_assertions
	import psc_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_DEF,
	parameter int DATA_W = DATA_W_DEF
) (
	// Clock and reset
	input wire logic				I_CLOCK,
	input wire logic				I_RESETN,
	// Register port
	input wire logic [ADDR_W-1:0]			I_REG_ADDR,
	input wire logic [DATA_W-1:0]			I_REG_WDATA,
	input wire logic				I_REG_WRITE,
	input wire logic				I_REG_READ,
	input wire logic [DATA_W-1:0]			O_REG_RDATA,
	// Pins
	input wire logic				O_STATUS_PIN_OE_N,
	input wire logic				I_POWER_DOWN_IN,
	input wire logic				I_CROSSOVER_DISABLE_IN,
	// Receive data toward the MAC
	input wire logic [3:0]				O_MAC_RXD,
	input wire logic				O_MAC_RXDV,
	// Configuration
	input wire logic [psc_pkg::MODE_W-1:0]		O_MODE,
	input wire logic				O_BLOCKS_POWER_ON,
	input wire logic				O_CORE_SOFT_RESET,
	input wire logic				O_AUTO_CROSSOVER_EN,
	input wire logic				O_RMII_MODE,
	input wire logic				O_SERIAL_SEVEN_WIRE_MODE
);
	// ==========================================================
	// Clocking, reset and sequences
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RESETN);
	// A soft-reset write and the single-cycle pulse it launches
	sequence ctrl_wr_s;
		I_REG_WRITE && I_REG_ADDR == REG_CONTROL && I_REG_WDATA[CTRL_SOFT_RESET_BIT];
	endsequence
	sequence pulse_s;
		O_CORE_SOFT_RESET ##1 !O_CORE_SOFT_RESET;
	endsequence

	// ==========================================================
	// Checks; pin inputs get one cycle of margin over the sync latency
	pd_quiet_a: assert property (I_POWER_DOWN_IN [*6] |-> !O_BLOCKS_POWER_ON && !O_MAC_RXDV && O_MAC_RXD == 4'h0)
		else $error("Outputs active while powered down");
	mode_read_a: assert property (I_REG_READ && I_REG_ADDR == REG_MODE && !O_STATUS_PIN_OE_N |=> O_REG_RDATA[7:0] == O_MODE)
		else $error("Mode readback differs from mode output");
	strap_hold_a: assert property (!O_STATUS_PIN_OE_N |=> $stable(O_MODE))
		else $error("Mode changed after capture");
	xover_off_a: assert property (I_CROSSOVER_DISABLE_IN [*5] |-> !O_AUTO_CROSSOVER_EN)
		else $error("Crossover left on while disabled");
	rmii_map_a: assert property (O_RMII_MODE |-> O_MAC_RXD[3:2] == 2'h0)
		else $error("Upper receive bits active in reduced mode");
	serial_map_a: assert property (O_SERIAL_SEVEN_WIRE_MODE |-> O_MAC_RXD[3:1] == 3'h0 && !O_MAC_RXDV)
		else $error("Unused receive pins active in serial mode");
	soft_pulse_a: assert property (ctrl_wr_s |=> pulse_s)
		else $error("Soft reset pulse missing or too long");
	pd_exit_a: assert property ($rose(O_BLOCKS_POWER_ON) |-> $past(O_CORE_SOFT_RESET) || $fell(O_STATUS_PIN_OE_N))
		else $error("Power came back without a reset");
endmodule

// >>> psc_mac_model.sv
/* MAC partner: drives the transmit pins with random traffic on the system clock.
   Assumes the device ignores whatever pins its selected pin map leaves unused. */
`timescale 1ns/10ps
module psc_mac_model (
	// Clock
	input wire logic	i_clock,
	// Transmit pins
	output logic [3:0]	o_txd,
	output logic		o_txen,
	output logic		o_txer
);
	int seed = 23;
	// ==========================================================
	// Quiet start, then random nibbles; unused bits stay busy so a leaky map shows
	initial begin
		o_txd = 4'h0;
		o_txen = 1'b0;
		o_txer = 1'b0;
	end
	always @(posedge i_clock) begin
		o_txd <= 4'($random(seed));
		o_txen <= 1'($random(seed));
		o_txer <= 1'($random(seed));
	end
endmodule

// >>> testbench.sv
/* Self-checking bench for the strap configuration block: straps per test, random core
   traffic, register access and power-down. Assumes the MAC model and checker files. */
`timescale 1ns/10ps
module testbench;
	import psc_pkg::*;
	// ==========================================================
	// Stimulus and observed signals
	logic		clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, pd = 1'b0, xdis = 1'b0, sd = 1'b0;
	logic [3:0]	addr = 4'h0;
	logic [15:0]	wd = 16'h0000, d;
	logic [5:0]	s = 6'h00;			// Straps: op code, status, reduced MII, receive clock
	logic [4:0]	pt = 5'h00, e;			// Per test: LED levels, cable, link
	logic [9:0]	cr = 10'h000, cp = 10'h000;	// Core receive side and the value it replaced
	logic [5:0]	th1 = 6'h00, th2 = 6'h00, th3 = 6'h00;	// MAC transmit pins, delayed like the pin path
	int		seed = 23, n_errors = 0, samples_checked = 0, cycles = 0;
	wire [15:0]	rdata;
	wire [7:0]	mode;
	wire [3:0]	mtxd, mrxd, ctxd;
	wire [2:0]	lo, oe;
	wire		mtxen, mtxer, so, so_n, co, co_n, ro, ro_n, mrxdv, mrxer, mcrs, ctxen, ctxer;
	wire		pon, srst, axo, sv, r50, rmii, ser;

	always #50 clk = ~clk;
	// Fresh core traffic every cycle; MAC pins delayed to line up with the synchronisers
	always @(posedge clk) begin
		cp <= cr;
		cr <= 10'($random(seed));
		th1 <= {mtxer, mtxen, mtxd};
		th2 <= th1;
		th3 <= th2;
	end
	// Hang guard, well above the dozen tests of about fifty cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			print_verdict();
		end
	end

	// Shared pins read the strap while released, the driven level otherwise
	psc_strap_config i_dut (
		.I_CLOCK(clk), .I_RESETN(rstn), .I_REG_ADDR(addr), .I_REG_WDATA(wd), .I_REG_WRITE(wr_s),
		.I_REG_READ(rd_s), .O_REG_RDATA(rdata),
		.I_INDICATOR_A_IN(oe[0] ? s[0] : lo[0]), .O_INDICATOR_A_OUT(lo[0]), .O_INDICATOR_A_OE_N(oe[0]),
		.I_INDICATOR_B_IN(oe[1] ? s[1] : lo[1]), .O_INDICATOR_B_OUT(lo[1]), .O_INDICATOR_B_OE_N(oe[1]),
		.I_INDICATOR_C_IN(oe[2] ? s[2] : lo[2]), .O_INDICATOR_C_OUT(lo[2]), .O_INDICATOR_C_OE_N(oe[2]),
		.I_STATUS_PIN_IN(so_n ? s[3] : so), .O_STATUS_PIN_OUT(so), .O_STATUS_PIN_OE_N(so_n),
		.I_COL_PIN_IN(co_n ? s[4] : co), .O_COL_PIN_OUT(co), .O_COL_PIN_OE_N(co_n),
		.I_RXCLK_PIN_IN(ro_n ? s[5] : ro), .O_RXCLK_PIN_OUT(ro), .O_RXCLK_PIN_OE_N(ro_n),
		.I_POWER_DOWN_IN(pd), .I_CROSSOVER_DISABLE_IN(xdis), .I_FIBER_SIGNAL_DETECT(sd),
		.I_MAC_TXD(mtxd), .I_MAC_TXEN(mtxen), .I_MAC_TXER(mtxer),
		.O_MAC_RXD(mrxd), .O_MAC_RXDV(mrxdv), .O_MAC_RXER(mrxer), .O_MAC_CRS(mcrs),
		.I_CORE_RXD(cr[3:0]), .I_CORE_RXDV(cr[4]), .I_CORE_RXER(cr[5]), .I_CORE_CRS(cr[6]), .I_CORE_COL(cr[7]),
		.I_CORE_RXCLK_LEVEL(cr[8]), .I_CORE_TP_SIGNAL(cr[9]), .I_CORE_CABLE_PRESENT(pt[3]),
		.I_CORE_LINK_UP(pt[4]), .I_CORE_LED_A(pt[0]), .I_CORE_LED_B(pt[1]), .I_CORE_LED_C(pt[2]),
		.O_CORE_TXD(ctxd), .O_CORE_TXEN(ctxen), .O_CORE_TXER(ctxer), .O_MODE(mode),
		.O_BLOCKS_POWER_ON(pon), .O_CORE_SOFT_RESET(srst), .O_AUTO_CROSSOVER_EN(axo),
		.O_RX_SIGNAL_VALID(sv), .O_REFCLK_50M_SEL(r50), .O_RMII_MODE(rmii), .O_SERIAL_SEVEN_WIRE_MODE(ser)
	);
	psc_mac_model i_mac (.i_clock(clk), .o_txd(mtxd), .o_txen(mtxen), .o_txer(mtxer));

	// ==========================================================
	// Expectations, comparison and bus cycles
	function automatic logic [7:0] exp_mode(input logic [2:0] c);
		logic [7:0] t [8] = '{8'h0B, 8'hA0, 8'hE0, 8'h00, 8'h40, 8'h20, 8'h60, 8'h1F};
		return t[c];
	endfunction
	// Receive side per pin map: {rxclk oe_n, rxclk, col oe_n, col, crs, rxer, rxdv, rxd}; reduced carries carrier as valid
	function automatic logic [10:0] exp_rx(input logic [9:0] c, input logic [5:0] t);
		if (t[4]) return {1'b1, c[8], 1'b1, c[7], 2'h0, c[6], 2'h0, c[1:0]};
		if (!t[5]) return {1'b0, c[8], 1'b0, c[7], c[6], 2'h0, 3'h0, c[0]};
		return {1'b0, c[8], 1'b0, c[7], c[6], c[5:0]};
	endfunction
	// Transmit toward the core per pin map: {txer, txen, txd}
	function automatic logic [5:0] exp_tx(input logic [5:0] h, input logic [5:0] t);
		if (t[4]) return {1'b0, h[4], 2'h0, h[1:0]};
		if (!t[5]) return {1'b0, h[4], 3'h0, h[0]};
		return h;
	endfunction
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wd <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// Straps cover serial, reduced and normal maps and both status meanings
	task automatic do_reset(input logic [3:0] n);
		@(posedge clk);
		s <= {n[1], n[0], n[2], n[2:0]};
		pt <= 5'($random(seed));
		xdis <= 1'($random(seed));
		sd <= 1'($random(seed));
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		cyc(10);
	endtask
	task automatic print_verdict;
		$display("Checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		for (int i = 0; i < 12; i++) begin
			do_reset(4'(i));
			e = {s[4], s[4], !s[5] && !s[4], !xdis, s[3] ? !pt[4] : pt[3]};
			chk("mode", 16'(mode), 16'(exp_mode(s[2:0])));
			chk("cfg", 16'({rmii, r50, ser, axo, so}), 16'(e));
			chk("leds", 16'({oe, lo}), 16'(pt[2:0] ^ s[2:0]));
			if (s[2:0] == OPM_FX100_HD || s[2:0] == OPM_FX100_FD) chk("sigdet", 16'(sv), 16'(sd));
			rd(REG_STRAP, d);
			chk("straps", d, 16'(s));
			rd(4'hF, d);
			chk("unmapped", d, 16'h0000);
			repeat (5) begin
				@(negedge clk);
				chk("rx", 16'({ro_n, ro, co_n, co, mcrs, mrxer, mrxdv, mrxd}), 16'(exp_rx(cp, s)));
				chk("tx", 16'({ctxer, ctxen, ctxd}), 16'(exp_tx(th3, s)));
			end
			@(posedge clk);
			pd <= 1'b1;
			cyc(6);
			chk("pd", 16'({pon, mrxdv, mrxd, ctxen}), 16'h0000);
			rd(REG_MODE, d);
			chk("pdread", d, 16'(exp_mode(s[2:0])));
			rd(REG_STATUS, d);
			chk("pdstat", d, 16'({!s[5] && !s[4], !xdis, 3'b011}));
			@(posedge clk);
			pd <= 1'b0;
			cyc(6);
			chk("pdhold", 16'(pon), 16'h0000);
			wr(REG_CONTROL, 16'h0001);
			cyc(3);
			chk("pdexit", 16'(pon), 16'h0001);
			$display("Test %0d done", i);
		end
		print_verdict();
	end
endmodule

bind psc_strap_config psc_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
	.I_CLOCK, .I_RESETN, .I_REG_ADDR, .I_REG_WDATA, .I_REG_WRITE, .I_REG_READ, .O_REG_RDATA,
	.O_STATUS_PIN_OE_N, .I_POWER_DOWN_IN, .I_CROSSOVER_DISABLE_IN, .O_MAC_RXD, .O_MAC_RXDV, .O_MODE,
	.O_BLOCKS_POWER_ON, .O_CORE_SOFT_RESET, .O_AUTO_CROSSOVER_EN, .O_RMII_MODE, .O_SERIAL_SEVEN_WIRE_MODE
);
